//--- rtl/crpm_consts.svh
// Purpose: constants of the core reset and power-mode sequencer
// Assumes: one core clock, four clock phases per instruction cycle
// Notes: offsets, field positions, reset values and timing counts only
`ifndef CRPM_CONSTS_SVH
`define CRPM_CONSTS_SVH

`define CRPM_PWR_CTRL_ADDR 8'h87
`define CRPM_PWR_CTRL_RESET 8'h00
`define CRPM_PWR_CTRL_MASK 8'h8f
`define CRPM_BIT_IDLE 0
`define CRPM_BIT_STOP 1
`define CRPM_BIT_FLAG_LOW 2
`define CRPM_BIT_FLAG_HIGH 3
`define CRPM_BIT_RATE_DOUBLER 7
`define CRPM_RESET_VECTOR 16'h0000
`define CRPM_PHASE_LAST 2'h3
`define CRPM_PHASE_RESET 2'h0
`define CRPM_CLK_PERIOD_NS 20
// Start delay in tenths of a clock cycle, rounded up to whole cycles
`define CRPM_START_DELAY_X10 15
`define CRPM_START_CYCLES ((`CRPM_START_DELAY_X10 + 9) / 10)

`endif

//--- rtl/crpm_pkg.sv
// Purpose: types of the core reset and power-mode sequencer
// Assumes: nothing beyond the constants header
// Notes: encodings written out
`default_nettype none
package crpm_pkg;
	typedef enum logic [1:0] {
		CRPM_RUN = 2'b00,
		CRPM_IDLE = 2'b01,
		CRPM_STOP = 2'b10
	} crpm_mode_e;
	typedef enum logic [1:0] {
		CRPM_RS_RUN = 2'b00,
		CRPM_RS_LOW1 = 2'b01,
		CRPM_RS_HELD = 2'b10,
		CRPM_RS_HIGH1 = 2'b11
	} crpm_rst_e;
endpackage
`default_nettype wire

//--- rtl/crpm_sync.sv
// Purpose: two-flop synchroniser for the slow pins
// Assumes: pins are asynchronous to the core clock
// Notes: the first stage is read only by the second
`default_nettype none
module crpm_sync
	import crpm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] pin_in,
	output logic [2:0] pin_sync
);
	logic [2:0] meta_reg;
	logic [2:0] sync_reg;

	// Pins idle high for reset, low for the interrupts
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= 3'h1;
			sync_reg <= 3'h1;
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
		end
	end

	assign pin_sync = sync_reg;
endmodule // crpm_sync
`default_nettype wire

//--- rtl/crpm_top.sv
// Purpose: reset sequencing and idle/stop control of the core
// Assumes: CPU pulses INSTR_DONE at each instruction end; INT_REQ is an enabled interrupt
// Notes: POR_N asserts asynchronously, releases through two flops
`include "crpm_consts.svh"
`default_nettype none
module crpm_top
	import crpm_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic POR_N,
	input wire logic RST_IN_N,
	input wire logic PFI,
	input wire logic WDTI,
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	output logic [7:0] SFR_RDATA,
	input wire logic INSTR_DONE,
	input wire logic INT_REQ,
	output logic RST_OUT_N,
	output logic IDLE_MODE_N,
	output logic STOP_MODE_N,
	output logic CPU_RUN,
	output logic CPU_START,
	output logic [15:0] START_ADDR,
	output logic [1:0] PHASE,
	output logic SERIAL_ZERO_RATE_DOUBLER,
	output logic POWER_FAIL_REQ,
	output logic WATCHDOG_EDGE
);
	logic por_meta_reg;
	logic por_ok_reg;
	logic [2:0] pins_s;
	logic rst_in_s;
	logic pfi_s;
	logic wdti_s;
	logic int_rst;
	logic fourth_phase;
	logic [1:0] phase_reg;
	crpm_rst_e rst_state_reg;
	crpm_rst_e rst_state_next;
	logic rst_out_n_reg;
	crpm_mode_e mode_reg;
	crpm_mode_e mode_next;
	logic idle_n_reg;
	logic stop_n_reg;
	logic [7:0] power_control_reg;
	logic [7:0] rdata_reg;
	logic [1:0] start_cnt_reg;
	logic start_reg;
	logic run_reg;
	logic pfi_lvl_reg;
	logic wdti_prev_reg;
	logic wdti_edge_reg;
	logic pc_write;

	function automatic logic sfr_hit(input logic [7:0] addr);
		sfr_hit = (addr == `CRPM_PWR_CTRL_ADDR);
	endfunction

	// Asynchronous assert, synchronous release; no outside synchroniser needed
	always_ff @(posedge REF_CLK or negedge POR_N) begin
		if (!POR_N) begin
			por_meta_reg <= 1'b0;
			por_ok_reg <= 1'b0;
		end else begin
			por_meta_reg <= 1'b1;
			por_ok_reg <= por_meta_reg;
		end
	end

	crpm_sync u_sync (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.pin_in({WDTI, PFI, RST_IN_N}),
		.pin_sync(pins_s)
	);
	assign rst_in_s = pins_s[0];
	assign pfi_s = pins_s[1];
	assign wdti_s = pins_s[2];

	// Mode, control and start logic reset from SYS_RST or the reset output; phase and reset state from SYS_RST or por_ok only
	assign int_rst = SYS_RST || !rst_out_n_reg;

	// Phase counter keeps running in standard reset so release can be seen
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST || !por_ok_reg) begin
			phase_reg <= `CRPM_PHASE_RESET;
		end else if (mode_reg == CRPM_STOP || mode_next == CRPM_STOP) begin
			phase_reg <= `CRPM_PHASE_RESET;
		end else begin
			phase_reg <= phase_reg + 2'h1;
		end
	end
	assign fourth_phase = (phase_reg == `CRPM_PHASE_LAST) && (mode_reg != CRPM_STOP);

	// Two equal samples in a row are needed to change reset state
	always_comb begin
		rst_state_next = rst_state_reg;
		if (fourth_phase) begin
			unique case (rst_state_reg)
				CRPM_RS_RUN: rst_state_next = rst_in_s ? CRPM_RS_RUN : CRPM_RS_LOW1;
				CRPM_RS_LOW1: rst_state_next = rst_in_s ? CRPM_RS_RUN : CRPM_RS_HELD;
				CRPM_RS_HELD: rst_state_next = rst_in_s ? CRPM_RS_HIGH1 : CRPM_RS_HELD;
				CRPM_RS_HIGH1: rst_state_next = rst_in_s ? CRPM_RS_RUN : CRPM_RS_HELD;
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST || !por_ok_reg) begin
			rst_state_reg <= CRPM_RS_RUN;
		end else begin
			rst_state_reg <= rst_state_next;
		end
	end

	// Release lags por_ok by one edge, so at least two clocks after POR_N rises
	always_ff @(posedge REF_CLK or negedge POR_N) begin
		if (!POR_N) begin
			rst_out_n_reg <= 1'b0;
		end else if (SYS_RST || !por_ok_reg) begin
			rst_out_n_reg <= 1'b0;
		end else begin
			rst_out_n_reg <= (rst_state_next == CRPM_RS_RUN) || (rst_state_next == CRPM_RS_LOW1);
		end
	end

	// Idle and stop are entered only at an instruction boundary; idle ends on INT_REQ
	always_comb begin
		mode_next = mode_reg;
		unique case (mode_reg)
			CRPM_RUN: begin
				if (INSTR_DONE && power_control_reg[`CRPM_BIT_STOP]) begin
					mode_next = CRPM_STOP;
				end else if (INSTR_DONE && power_control_reg[`CRPM_BIT_IDLE]) begin
					mode_next = CRPM_IDLE;
				end
			end
			CRPM_IDLE: begin
				if (INT_REQ) begin
					mode_next = CRPM_RUN;
				end
			end
			CRPM_STOP: mode_next = CRPM_STOP;
			default: mode_next = CRPM_RUN;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (int_rst) begin
			mode_reg <= CRPM_RUN;
		end else begin
			mode_reg <= mode_next;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (int_rst) begin
			idle_n_reg <= 1'b1;
			stop_n_reg <= 1'b1;
		end else begin
			idle_n_reg <= (mode_next != CRPM_IDLE);
			stop_n_reg <= (mode_next != CRPM_STOP);
		end
	end

	assign pc_write = SFR_WR && sfr_hit(SFR_ADDR);

	// A software write of the idle bit beats the hardware clear
	always_ff @(posedge REF_CLK) begin
		if (int_rst) begin
			power_control_reg <= `CRPM_PWR_CTRL_RESET;
		end else if (pc_write) begin
			power_control_reg <= SFR_WDATA & `CRPM_PWR_CTRL_MASK;
		end else if (mode_reg == CRPM_IDLE && INT_REQ) begin
			power_control_reg[`CRPM_BIT_IDLE] <= 1'b0;
		end
	end

	// Unmapped reads answer zero; reserved bits read zero
	always_ff @(posedge REF_CLK) begin
		if (int_rst) begin
			rdata_reg <= 8'h00;
		end else if (SFR_RD) begin
			rdata_reg <= sfr_hit(SFR_ADDR) ? power_control_reg : 8'h00;
		end
	end

	// 1.5 clocks cannot be hit on one edge; the later rising edge is used
	always_ff @(posedge REF_CLK) begin
		if (int_rst) begin
			start_cnt_reg <= 2'(`CRPM_START_CYCLES);
			start_reg <= 1'b0;
			run_reg <= 1'b0;
		end else begin
			start_reg <= (start_cnt_reg == 2'h1);
			if (start_cnt_reg != 2'h0) begin
				start_cnt_reg <= start_cnt_reg - 2'h1;
			end
			run_reg <= (start_cnt_reg <= 2'h1) && (mode_next == CRPM_RUN);
		end
	end

	// Power-fail is a level, watchdog a rising edge, both taken at the fourth phase
	always_ff @(posedge REF_CLK) begin
		if (int_rst) begin
			pfi_lvl_reg <= 1'b0;
			wdti_prev_reg <= 1'b0;
			wdti_edge_reg <= 1'b0;
		end else begin
			wdti_edge_reg <= fourth_phase && wdti_s && !wdti_prev_reg;
			if (fourth_phase) begin
				pfi_lvl_reg <= pfi_s;
				wdti_prev_reg <= wdti_s;
			end
		end
	end

	assign SFR_RDATA = rdata_reg;
	assign RST_OUT_N = rst_out_n_reg;
	assign IDLE_MODE_N = idle_n_reg;
	assign STOP_MODE_N = stop_n_reg;
	assign CPU_RUN = run_reg;
	assign CPU_START = start_reg;
	assign START_ADDR = `CRPM_RESET_VECTOR;
	assign PHASE = phase_reg;
	assign SERIAL_ZERO_RATE_DOUBLER = power_control_reg[`CRPM_BIT_RATE_DOUBLER];
	assign POWER_FAIL_REQ = pfi_lvl_reg;
	assign WATCHDOG_EDGE = wdti_edge_reg;

	sequence s_por_release;
		$rose(por_ok_reg) ##0 (rst_state_reg == CRPM_RS_RUN);
	endsequence

	sequence s_out_release;
		!RST_OUT_N ##1 RST_OUT_N;
	endsequence

	sequence s_second_low;
		fourth_phase && (rst_state_reg == CRPM_RS_LOW1) && !rst_in_s;
	endsequence

	sequence s_second_high;
		fourth_phase && (rst_state_reg == CRPM_RS_HIGH1) && rst_in_s;
	endsequence

	a_por_drives_out: assert property (@(posedge REF_CLK) !por_ok_reg |-> !RST_OUT_N)
		else $error("reset output inactive while power-on reset held");

	a_por_release_gap: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		s_por_release |-> s_out_release)
		else $error("reset output not released one clock after power-on release");

	// The start pulse is registered twice behind the release edge
	a_start_delay: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		$rose(RST_OUT_N) |-> !CPU_START ##1 !CPU_START ##1 CPU_START ##1 !CPU_START)
		else $error("execution start not two clocks after reset release");

	a_std_entry: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		s_second_low |=> !RST_OUT_N && (rst_state_reg == CRPM_RS_HELD))
		else $error("second low sample did not assert reset output");

	a_std_single_low: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		fourth_phase && (rst_state_reg == CRPM_RS_LOW1) && rst_in_s |=> RST_OUT_N)
		else $error("single low sample caused reset");

	a_std_release: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		s_second_high ##0 por_ok_reg |=> RST_OUT_N ##2 CPU_START)
		else $error("standard reset release timing wrong");

	a_stop_phase_held: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		(mode_reg == CRPM_STOP) && rst_out_n_reg |=> (PHASE == 2'h0) [*2])
		else $error("phase counter ran in stop mode");

	a_stop_sticky: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		!STOP_MODE_N && por_ok_reg |=> !STOP_MODE_N)
		else $error("stop mode left without power-on reset");

	a_idle_exit: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		(mode_reg == CRPM_IDLE) && INT_REQ && !pc_write && RST_OUT_N |=>
		IDLE_MODE_N && !power_control_reg[`CRPM_BIT_IDLE])
		else $error("interrupt did not end idle mode");

	a_stop_wins: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		(mode_reg == CRPM_RUN) && INSTR_DONE && (power_control_reg[1:0] == 2'h3) && RST_OUT_N |=>
		!STOP_MODE_N && IDLE_MODE_N && !CPU_RUN)
		else $error("stop did not take precedence over idle");

	a_reset_clears: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		!RST_OUT_N && POR_N |=> (power_control_reg == 8'h00) && IDLE_MODE_N && STOP_MODE_N)
		else $error("reset left control state set");

	a_idle_entry: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		(mode_reg == CRPM_RUN) && INSTR_DONE && power_control_reg[`CRPM_BIT_IDLE] &&
		!power_control_reg[`CRPM_BIT_STOP] && RST_OUT_N |=> !IDLE_MODE_N && STOP_MODE_N && !CPU_RUN)
		else $error("idle bit did not enter idle mode");

	a_idle_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		(mode_reg == CRPM_IDLE) && !INT_REQ && RST_OUT_N |=> !IDLE_MODE_N && !CPU_RUN)
		else $error("idle mode left without interrupt or reset");

	a_idle_std_reset: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		(mode_reg == CRPM_IDLE) && !RST_OUT_N |=> IDLE_MODE_N && (mode_reg == CRPM_RUN))
		else $error("reset did not end idle mode");

	a_reserved_zero: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		(power_control_reg & ~`CRPM_PWR_CTRL_MASK) == 8'h00)
		else $error("reserved control bits set");

	a_flag_write: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		pc_write && RST_OUT_N |=> (SERIAL_ZERO_RATE_DOUBLER == $past(SFR_WDATA[`CRPM_BIT_RATE_DOUBLER])) &&
		(power_control_reg[`CRPM_BIT_FLAG_HIGH:`CRPM_BIT_FLAG_LOW] ==
		$past(SFR_WDATA[`CRPM_BIT_FLAG_HIGH:`CRPM_BIT_FLAG_LOW])))
		else $error("control write did not land");

	a_read_hit: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		SFR_RD && sfr_hit(SFR_ADDR) && RST_OUT_N |=> SFR_RDATA == $past(power_control_reg))
		else $error("control read returned wrong data");

	a_read_miss: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		SFR_RD && !sfr_hit(SFR_ADDR) && RST_OUT_N |=> SFR_RDATA == 8'h00)
		else $error("unmapped read not zero");

	a_halt_in_reset: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		!RST_OUT_N |=> !CPU_RUN && !CPU_START)
		else $error("execution allowed during reset");

	a_pfi_level: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		fourth_phase && RST_OUT_N |=> POWER_FAIL_REQ == $past(pfi_s))
		else $error("power-fail level not taken at fourth phase");

	a_wd_rise: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		fourth_phase && wdti_s && !wdti_prev_reg && RST_OUT_N |=> WATCHDOG_EDGE)
		else $error("watchdog rising edge missed");

	a_wd_single: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		WATCHDOG_EDGE |=> !WATCHDOG_EDGE)
		else $error("watchdog edge pulse longer than one cycle");

	a_phase_step: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		(mode_reg != CRPM_STOP) && (mode_next != CRPM_STOP) && por_ok_reg |=> PHASE == $past(PHASE) + 2'h1)
		else $error("phase counter did not advance");

	a_stop_phase_entry: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		(mode_reg == CRPM_RUN) && (mode_next == CRPM_STOP) |=> PHASE == 2'h0)
		else $error("phase counter not cleared on stop entry");

	a_stop_holds_out: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		(mode_reg == CRPM_STOP) && RST_OUT_N |=> RST_OUT_N)
		else $error("standard reset taken in stop mode");

	a_modes_exclusive: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !POR_N)
		IDLE_MODE_N || STOP_MODE_N)
		else $error("idle and stop indicators active together");
endmodule // crpm_top
`default_nettype wire

//--- testbench/crpm_reset_src.sv
// Purpose: model of the external reset sources and the clock-removal logic
// Assumes: commands are one-cycle pulses driven just after a rising edge
// Notes: a short standard reset pulse is produced only when the bench asks for one
`default_nettype none
module crpm_reset_src (
	input wire logic clk,
	input wire logic por_go,
	input wire logic rst_go,
	input wire logic [4:0] rst_len,
	input wire logic stop_mode_n,
	output logic por_n,
	output logic rst_in_n,
	output logic clk_en
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] por_cnt_reg = 2'h3;
	logic [4:0] rst_cnt_reg = 5'h00;
	// Three clocks low leaves one clock of margin over the minimum
	always @(posedge clk) begin
		if (por_go)
			por_cnt_reg <= 2'h3;
		else if (por_cnt_reg != 2'h0)
			por_cnt_reg <= por_cnt_reg - 2'h1;
	end
	always @(posedge clk) begin
		if (rst_go)
			rst_cnt_reg <= rst_len;
		else if (rst_cnt_reg != 5'h00)
			rst_cnt_reg <= rst_cnt_reg - 5'h01;
	end
	assign por_n = (por_cnt_reg == 2'h0);
	assign rst_in_n = (rst_cnt_reg == 5'h00);
	// The core keeps its clock running in stop, so removal happens out here
	assign clk_en = stop_mode_n;
endmodule // crpm_reset_src
`default_nettype wire

//--- testbench/tb_crpm_top.sv
// Purpose: self-checking bench of the reset and power-mode sequencer
// Assumes: reset pins come from the partner model, register bus driven here
// Notes: timings are counted in falling edges, where outputs have settled
`include "crpm_consts.svh"
`default_nettype none
module tb_crpm_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic por_go = 1'b1, rst_go = 1'b0, pfi = 1'b0, wdti = 1'b0, wr = 1'b0, rd = 1'b0, done = 1'b0, irq = 1'b0;
	logic [4:0] rst_len = 5'h0c;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic por_n, rst_in_n, clk_en, rst_out_n, idle_n, stop_n, cpu_run, cpu_start, dbl, pf_req, wd_edge;
	logic [15:0] start_addr;
	logic [1:0] phase;
	logic low_seen = 1'b0;
	int failures = 0, cmp_count = 0, cyc = 0, wd_seen = 0, n = 0;

	always #10 clk = ~clk;

	crpm_reset_src src (.clk(clk), .por_go(por_go), .rst_go(rst_go), .rst_len(rst_len), .stop_mode_n(stop_n),
		.por_n(por_n), .rst_in_n(rst_in_n), .clk_en(clk_en));
	crpm_top dut (.REF_CLK(clk), .SYS_RST(sys_rst), .POR_N(por_n), .RST_IN_N(rst_in_n), .PFI(pfi), .WDTI(wdti),
		.SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .INSTR_DONE(done),
		.INT_REQ(irq), .RST_OUT_N(rst_out_n), .IDLE_MODE_N(idle_n), .STOP_MODE_N(stop_n), .CPU_RUN(cpu_run),
		.CPU_START(cpu_start), .START_ADDR(start_addr), .PHASE(phase), .SERIAL_ZERO_RATE_DOUBLER(dbl),
		.POWER_FAIL_REQ(pf_req), .WATCHDOG_EDGE(wd_edge));

	always @(negedge clk) begin
		if (rst_out_n === 1'b0)
			low_seen = 1'b1;
		if (wd_edge === 1'b1)
			wd_seen++;
	end
	// Whole run is a few hundred cycles; the ceiling leaves wide margin
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			close_out();
		end
	end

	task close_out();
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task cycles(input int k);
		repeat (k) @(negedge clk);
	endtask
	task wr8(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd8(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("register read", exp, rdata);
	endtask
	task mode(input logic [7:0] v);
		wr8(`CRPM_PWR_CTRL_ADDR, v);
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		@(negedge clk);
	endtask
	task pulse(input logic por, input logic [4:0] len);
		@(posedge clk);
		rst_len <= len;
		rst_go <= ~por;
		por_go <= por;
		@(posedge clk);
		rst_go <= 1'b0;
		por_go <= 1'b0;
		@(negedge clk);
	endtask
	// Counts falling edges until the reset output reaches the given level
	task wait_rst(input logic lvl);
		n = 0;
		while (rst_out_n !== lvl && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (rst_out_n !== lvl) begin
			chk("reset output level", lvl, rst_out_n);
			close_out();
		end
	endtask
	task wait_start();
		n = 0;
		while (cpu_start !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (cpu_start !== 1'b1) begin
			chk("start pulse", 16'h1, cpu_start);
			close_out();
		end
	endtask
	task por_release();
		while (por_n !== 1'b1)
			@(negedge clk);
		wait_rst(1'b1);
	endtask

	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		por_go <= 1'b0;
		por_release();
		chk("por release delay", 16'd3, 16'(n));
		wait_start();
		chk("start delay", `CRPM_START_CYCLES, 16'(n));
		chk("start address", `CRPM_RESET_VECTOR, start_addr);
		$display("test power_on done");
		rd8(`CRPM_PWR_CTRL_ADDR, `CRPM_PWR_CTRL_RESET);
		wr8(`CRPM_PWR_CTRL_ADDR, 8'hfc);
		wr8(8'h88, 8'hff);
		rd8(`CRPM_PWR_CTRL_ADDR, 8'hfc & `CRPM_PWR_CTRL_MASK);
		rd8(8'h88, 8'h00);
		chk("rate doubler", 16'h1, dbl);
		wr8(`CRPM_PWR_CTRL_ADDR, 8'h00);
		$display("test registers done");
		mode(8'h01);
		chk("idle indicator", 16'h0, idle_n);
		chk("run in idle", 16'h0, cpu_run);
		@(posedge clk);
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
		@(negedge clk);
		chk("idle after interrupt", 16'h1, idle_n);
		chk("run after interrupt", 16'h1, cpu_run);
		rd8(`CRPM_PWR_CTRL_ADDR, 8'h00);
		$display("test idle done");
		mode(8'h8d);
		pulse(1'b0, 5'h0c);
		wait_rst(1'b0);
		chk("phase at assertion", 16'h0, phase);
		// Inner state clears one edge after the reset output falls
		cycles(1);
		chk("idle during reset", 16'h1, idle_n);
		chk("doubler in reset", 16'h0, dbl);
		wait_rst(1'b1);
		chk("phase at release", 16'h0, phase);
		wait_start();
		chk("restart delay", `CRPM_START_CYCLES, 16'(n));
		rd8(`CRPM_PWR_CTRL_ADDR, `CRPM_PWR_CTRL_RESET);
		low_seen = 1'b0;
		pulse(1'b0, 5'h03);
		cycles(24);
		chk("short pulse", 16'h0, low_seen);
		$display("test standard_reset done");
		@(posedge clk);
		pfi <= 1'b1;
		wdti <= 1'b1;
		wd_seen = 0;
		cycles(12);
		chk("power fail level", 16'h1, pf_req);
		chk("watchdog edges", 16'h1, 16'(wd_seen));
		@(posedge clk);
		pfi <= 1'b0;
		cycles(12);
		chk("power fail cleared", 16'h0, pf_req);
		$display("test interrupt_pins done");
		mode(8'h03);
		chk("stop indicator", 16'h0, stop_n);
		chk("idle with stop", 16'h1, idle_n);
		cycles(8);
		chk("phase in stop", 16'h0, phase);
		chk("clock removed", 16'h0, clk_en);
		chk("run in stop", 16'h0, cpu_run);
		low_seen = 1'b0;
		@(posedge clk);
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
		pulse(1'b0, 5'h0c);
		cycles(30);
		chk("stop kept", 16'h0, stop_n);
		chk("no standard reset", 16'h0, low_seen);
		pulse(1'b1, 5'h00);
		chk("por aborts", 16'h0, rst_out_n);
		por_release();
		chk("por release in stop", 16'd3, 16'(n));
		chk("stop ended", 16'h1, stop_n);
		$display("test stop done");
		close_out();
	end
endmodule // tb_crpm_top
`default_nettype wire
